// >>> common/cfg_cmd_pkg.sv
// package of constants and types for the serial configuration command parser
package cfg_cmd_pkg;

   // =========================================================
   // character codes
   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] CH_QMARK = 8'h3F;
   localparam logic [7:0] CH_C     = 8'h43;
   localparam logic [7:0] CH_P     = 8'h50;
   localparam logic [7:0] CH_0     = 8'h30;

   // =========================================================
   // error codes sent after the question mark
   localparam logic [3:0] ERR_HEADER   = 4'h1;
   localparam logic [3:0] ERR_LENGTH   = 4'h2;
   localparam logic [3:0] ERR_CHECKSUM = 4'h3;
   localparam logic [3:0] ERR_TIMEOUT  = 4'h5;

   // =========================================================
   // frame layout and limits
   localparam int         LINE_MAX      = 24;
   localparam logic [4:0] LEN_CLEAR     = 5'd1;
   localparam logic [4:0] LEN_LINK      = 5'd9;
   localparam logic [4:0] LEN_CAN       = 5'd3;
   localparam logic [4:0] LEN_VCAN      = 5'd19;
   localparam logic [3:0] LINK_RATE_MAX = 4'hE;
   localparam logic [3:0] CAN_RATE_MAX  = 4'h9;

   // =========================================================
   // reset values: 115200 bit/s, 8 data bits, 1 stop, no parity, no checksum
   localparam logic [3:0] RST_LINK_RATE = 4'hB;
   localparam logic [1:0] RST_DATA_BITS = 2'd3;
   localparam logic [3:0] RST_CAN_RATE  = 4'h4;

   // =========================================================
   // receive timeout
   localparam int TIMEOUT_MS     = 100;
   localparam int CLK_HZ         = 40_000_000;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);

   typedef struct packed {
      logic [3:0] link_rate_code;
      logic [1:0] data_bits;
      logic       two_stop;
      logic [1:0] parity;
      logic       checksum_on;
      logic       err_reply_on;
   } link_cfg_s;

   // decode one hex character, bit 4 set when not a hex digit
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) hex_val = {1'b0, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
         hex_val = {1'b0, 4'(c[3:0] + 4'h9)};
      else hex_val = 5'h10;
   endfunction

   function automatic logic [7:0] hex_chr(input logic [3:0] v);
      hex_chr = (v < 4'hA) ? {4'h3, v} : {4'h4, 4'(v - 4'h9)};
   endfunction

endpackage

// >>> core/reply_sender.sv
// reply serialiser: sends ? code [checksum] CR with handshake
`timescale 1ns/1ps
`default_nettype none
module reply_sender
   import cfg_cmd_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       clk_en_i,
   input  wire logic       start_i,
   input  wire logic [3:0] code_i,
   input  wire logic       with_sum_i,
   input  wire logic       tx_ready_i,
   output logic            tx_valid_o,
   output logic [7:0]      tx_data_o,
   output logic            busy_o
);
   logic [2:0] idx;
   logic [7:0] chars [5];
   logic [7:0] sum;
   logic [2:0] last;

   // checksum is the byte sum of question mark and code digit
   always_comb begin
      sum = 8'(CH_QMARK + hex_chr(code_i));
      chars[0] = CH_QMARK;
      chars[1] = hex_chr(code_i);
      chars[2] = with_sum_i ? hex_chr(sum[7:4]) : CH_CR;
      chars[3] = hex_chr(sum[3:0]);
      chars[4] = CH_CR;
      last = with_sum_i ? 3'd4 : 3'd2;
   end

   // walk the character index while the sink accepts
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_o <= 1'b0;
         idx    <= 3'd0;
      end else if (clk_en_i) begin
         if (!busy_o && start_i) begin
            busy_o <= 1'b1;
            idx    <= 3'd0;
         end else if (busy_o && tx_ready_i) begin
            if (idx == last) busy_o <= 1'b0;
            idx <= 3'(idx + 3'd1);
         end
      end
   end

   assign tx_valid_o = busy_o;
   assign tx_data_o  = busy_o ? chars[idx] : 8'h00;

   a_reply_opens: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && !busy_o && start_i |=> tx_data_o == CH_QMARK)
      else $error("reply does not open with question mark");
endmodule
`default_nettype wire

// >>> core/serial_config_command_parser.sv
// command interpreter for host-link and CAN configuration commands
//
// Operation
// - valid clear command clears fifo overflow flag and sends no reply
// - accepted clear command turns off fault indicator lit by overflow
// - rejected command replies question mark, error code, checksum, CR when the reply field is on
// - link command: header, two-char rate code, data, stop, parity, sum, reply
// - data field 0..3 selects 5..8 character bits
// - stop field 0 gives one stop bit, 1 gives two
// - parity field 0 none, 1 odd, 2 even
// - checksum field 0 without, 1 with frame checksum
// - link rate codes 00..0B select 110 to 115200 bit/s
// - link rate codes 0C..0E select 230400 to 921600 bit/s
// - persistent link command stores parameters then reboots
// - CAN rate code 0..9 selects 10K to 83.3K
// - persistent CAN rate command stores rate then reboots
// - persistent CAN rate accepts listed codes only, no user rate
// - volatile link command applies now, stored settings return at reboot
// - volatile CAN command holds CAN settings volatile until reboot
// - checksum is low byte of character sum, two hex characters
// - error codes: 1 header, 2 length, 3 checksum, 5 timeout
`timescale 1ns/1ps
`default_nettype none
module serial_config_command_parser
   import cfg_cmd_pkg::*;
#(
   parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
)(
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output logic             rx_ready_o,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   input  wire logic        tx_ready_i,
   input  wire logic        overflow_set_i,
   input  wire link_cfg_s   stored_link_i,
   input  wire logic [3:0]  stored_can_rate_i,
   output logic             overflow_flag_o,
   output logic             fault_indicator_o,
   output link_cfg_s        link_cfg_o,
   output logic [3:0]       can_rate_o,
   output logic [63:0]      can_filter_o,
   output logic             can_filter_load_o,
   output logic             nv_write_o,
   output link_cfg_s        nv_link_o,
   output logic [3:0]       nv_can_rate_o,
   output logic             nv_link_sel_o,
   input  wire logic        nv_done_i,
   output logic             reboot_cmd_o
);
   typedef enum logic [2:0] {
      ST_RECV  = 3'b000,
      ST_CHECK = 3'b001,
      ST_EXEC  = 3'b010,
      ST_NVWR  = 3'b011,
      ST_REPLY = 3'b100
   } state_e;

   state_e      state;
   logic [7:0]  line [LINE_MAX];
   logic [4:0]  len;
   logic [7:0]  run_sum;
   logic [7:0]  body_sum;
   logic        overrun;
   logic [31:0] idle_cnt;
   logic        timeout;
   logic [3:0]  err_code;
   logic [3:0]  cmd;
   logic [4:0]  body_len;
   logic        sum_ok;
   logic        fields_ok;
   logic        hdr_ok;
   logic        len_ok;
   link_cfg_s   new_link;
   logic [4:0]  rate_hi;
   logic [4:0]  rate_lo;
   logic [4:0]  can_digit;
   logic        reply_busy;
   logic        reply_start;
   logic [4:0]  sum_hi;
   logic [4:0]  sum_lo;
   logic [7:0]  sum_sub;

   localparam logic [3:0] CMD_NONE = 4'd0;
   localparam logic [3:0] CMD_CLR  = 4'd1;
   localparam logic [3:0] CMD_PLNK = 4'd2;
   localparam logic [3:0] CMD_PCAN = 4'd3;
   localparam logic [3:0] CMD_VLNK = 4'd4;
   localparam logic [3:0] CMD_VCAN = 4'd5;

   // =========================================================
   // receive path: gather the line until CR
   assign rx_ready_o = (state == ST_RECV);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         len     <= 5'd0;
         run_sum <= 8'h00;
         overrun <= 1'b0;
      end else if (clk_en_i) begin
         if (state == ST_RECV && rx_valid_i && rx_data_i != CH_CR) begin
            if (len < 5'(LINE_MAX)) begin
               line[len] <= rx_data_i;
               len       <= 5'(len + 5'd1);
            end else begin
               overrun <= 1'b1;
            end
            run_sum <= 8'(run_sum + rx_data_i);
         end else if (state == ST_EXEC || (state == ST_RECV && timeout)) begin
            len     <= 5'd0;
            run_sum <= 8'h00;
            overrun <= 1'b0;
         end
      end
   end

   // idle counter for incomplete frames, restarts on every character
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idle_cnt <= 32'd0;
      end else if (clk_en_i) begin
         if (state != ST_RECV || len == 5'd0 || rx_valid_i) idle_cnt <= 32'd0;
         else idle_cnt <= idle_cnt + 32'd1;
      end
   end
   assign timeout = (state == ST_RECV) && (len != 5'd0) && !rx_valid_i
                    && (idle_cnt >= 32'(TIMEOUT_LIMIT - 1));

   // =========================================================
   // decode header, length, fields and checksum
   always_comb begin
      cmd = CMD_NONE;
      body_len = 5'd0;
      if (line[0] == CH_C) begin
         cmd = CMD_CLR;
         body_len = LEN_CLEAR;
      end else if (line[0] == CH_P && len >= 5'd2) begin
         unique case (line[1])
            8'h30: begin cmd = CMD_PLNK; body_len = LEN_LINK; end
            8'h31: begin cmd = CMD_PCAN; body_len = LEN_CAN;  end
            8'h32: begin cmd = CMD_VLNK; body_len = LEN_LINK; end
            8'h33: begin cmd = CMD_VCAN; body_len = LEN_VCAN; end
            default: cmd = CMD_NONE;
         endcase
      end
      hdr_ok = (cmd != CMD_NONE) && (len != 5'd0);
      // a checksum adds two characters when the link runs with checksums
      len_ok = !overrun && (len == 5'(body_len + (link_cfg_o.checksum_on ? 5'd2 : 5'd0)));
      sum_hi = hex_val(line[5'(body_len)]);
      sum_lo = hex_val(line[5'(body_len + 5'd1)]);
      sum_sub = 8'(line[5'(body_len)] + line[5'(body_len + 5'd1)]);
      body_sum = 8'(run_sum - sum_sub);
      sum_ok = !link_cfg_o.checksum_on
               || (!sum_hi[4] && !sum_lo[4] && {sum_hi[3:0], sum_lo[3:0]} == body_sum);
      // link fields sit after the two header characters
      rate_hi = hex_val(line[2]);
      rate_lo = hex_val(line[3]);
      new_link.link_rate_code = rate_lo[3:0];
      new_link.data_bits      = 2'(line[4] - CH_0);
      new_link.two_stop       = line[5][0];
      new_link.parity         = 2'(line[6] - CH_0);
      new_link.checksum_on    = line[7][0];
      new_link.err_reply_on   = line[8][0];
      can_digit = hex_val(line[2]);
      fields_ok = 1'b1;
      if (cmd == CMD_PLNK || cmd == CMD_VLNK) begin
         fields_ok = rate_hi == 5'd0 && !rate_lo[4]
                     && rate_lo[3:0] <= LINK_RATE_MAX
                     && line[4] >= CH_0 && line[4] <= 8'h33
                     && (line[5] == CH_0 || line[5] == 8'h31)
                     && line[6] >= CH_0 && line[6] <= 8'h32
                     && (line[7] == CH_0 || line[7] == 8'h31)
                     && (line[8] == CH_0 || line[8] == 8'h31);
      end else if (cmd == CMD_PCAN || cmd == CMD_VCAN) begin
         fields_ok = !can_digit[4] && can_digit[3:0] <= CAN_RATE_MAX;
      end
   end

   // =========================================================
   // command sequencer
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state    <= ST_RECV;
         err_code <= 4'h0;
      end else if (clk_en_i) begin
         unique case (state)
            ST_RECV: begin
               if (timeout) begin
                  err_code <= ERR_TIMEOUT;
                  state    <= ST_REPLY;
               end else if (rx_valid_i && rx_data_i == CH_CR) begin
                  state <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (!hdr_ok) err_code <= ERR_HEADER;
               else if (!len_ok || !fields_ok) err_code <= ERR_LENGTH;
               else if (!sum_ok) err_code <= ERR_CHECKSUM;
               else err_code <= 4'h0;
               state <= ST_EXEC;
            end
            ST_EXEC: begin
               if (err_code != 4'h0) state <= ST_REPLY;
               else if (cmd == CMD_PLNK || cmd == CMD_PCAN) state <= ST_NVWR;
               else state <= ST_RECV;
            end
            ST_NVWR: if (nv_done_i) state <= ST_RECV;
            ST_REPLY: if (!reply_busy && !reply_start) state <= ST_RECV;
            default: state <= ST_RECV;
         endcase
      end
   end

   // error replies only go out when the reply field enables them
   assign reply_start = (state == ST_EXEC && err_code != 4'h0 && link_cfg_o.err_reply_on)
                        || (state == ST_RECV && timeout && link_cfg_o.err_reply_on);

   // =========================================================
   // overflow flag and indicator; a set in the clear cycle wins
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         overflow_flag_o   <= 1'b0;
         fault_indicator_o <= 1'b0;
      end else if (clk_en_i) begin
         if (overflow_set_i) begin
            overflow_flag_o   <= 1'b1;
            fault_indicator_o <= 1'b1;
         end else if (state == ST_EXEC && err_code == 4'h0 && cmd == CMD_CLR) begin
            overflow_flag_o   <= 1'b0;
            fault_indicator_o <= 1'b0;
         end
      end
   end

   // =========================================================
   // live settings: volatile commands apply now, stored values load after reset
   logic loaded;
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         loaded     <= 1'b0;
         link_cfg_o <= '{RST_LINK_RATE, RST_DATA_BITS, 1'b0, 2'd0, 1'b0, 1'b0};
         can_rate_o <= RST_CAN_RATE;
      end else if (clk_en_i) begin
         if (!loaded) begin
            loaded     <= 1'b1;
            link_cfg_o <= stored_link_i;
            can_rate_o <= stored_can_rate_i;
         end else if (state == ST_EXEC && err_code == 4'h0) begin
            if (cmd == CMD_VLNK) link_cfg_o <= new_link;
            if (cmd == CMD_VCAN) can_rate_o <= can_digit[3:0];
         end
      end
   end

   // filter code and mask of the volatile CAN command, sixteen hex digits
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         can_filter_o      <= 64'h0;
         can_filter_load_o <= 1'b0;
      end else if (clk_en_i) begin
         can_filter_load_o <= state == ST_EXEC && err_code == 4'h0 && cmd == CMD_VCAN;
         if (state == ST_EXEC && err_code == 4'h0 && cmd == CMD_VCAN) begin
            for (int i = 0; i < 16; i++) begin
               can_filter_o[60 - 4 * i +: 4] <= 4'(line[3 + i][3:0] + (line[3 + i][6] ? 4'h9 : 4'h0));
            end
         end
      end
   end

   // =========================================================
   // persistent commands: write non-volatile store, then reboot
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         nv_write_o    <= 1'b0;
         nv_link_o     <= '0;
         nv_can_rate_o <= 4'h0;
         nv_link_sel_o <= 1'b0;
         reboot_cmd_o  <= 1'b0;
      end else if (clk_en_i) begin
         reboot_cmd_o <= state == ST_NVWR && nv_done_i;
         if (state == ST_EXEC && err_code == 4'h0
             && (cmd == CMD_PLNK || cmd == CMD_PCAN)) begin
            nv_write_o    <= 1'b1;
            nv_link_sel_o <= cmd == CMD_PLNK;
            nv_link_o     <= new_link;
            nv_can_rate_o <= can_digit[3:0];
         end else if (nv_done_i) begin
            nv_write_o <= 1'b0;
         end
      end
   end

   reply_sender u_reply (
      .ref_clk_i  (ref_clk_i),
      .arst_n_i   (arst_n_i),
      .clk_en_i   (clk_en_i),
      .start_i    (reply_start),
      .code_i     (err_code == 4'h0 ? ERR_TIMEOUT : err_code),
      .with_sum_i (1'b1),
      .tx_ready_i (tx_ready_i),
      .tx_valid_o (tx_valid_o),
      .tx_data_o  (tx_data_o),
      .busy_o     (reply_busy)
   );

   // =========================================================
   // checks
   a_clear_silent: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == ST_EXEC && err_code == 4'h0 && cmd == CMD_CLR && !overflow_set_i
      |=> !overflow_flag_o && !fault_indicator_o && !tx_valid_o)
      else $error("clear command misbehaved");
   a_set_wins: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && overflow_set_i |=> overflow_flag_o && fault_indicator_o)
      else $error("overflow event lost");
   a_cr_gates: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == ST_RECV && !(rx_valid_i && rx_data_i == CH_CR) && !timeout
      |=> state == ST_RECV)
      else $error("checked before terminator");
   a_reboot_after: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(reboot_cmd_o) |-> $past(nv_write_o))
      else $error("reboot without store");
   a_no_reply_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !link_cfg_o.err_reply_on && !reply_busy |=> !tx_valid_o)
      else $error("error reply while disabled");
   a_rate_range: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      nv_write_o && !nv_link_sel_o |-> nv_can_rate_o <= CAN_RATE_MAX)
      else $error("CAN rate out of list");
   a_timeout_code: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == ST_RECV && timeout |=> state == ST_REPLY && err_code == ERR_TIMEOUT)
      else $error("receive timeout not reported");
   // a volatile CAN command loads the filter and never touches the store
   a_volatile_can: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      clk_en_i && state == ST_EXEC && err_code == 4'h0 && cmd == CMD_VCAN
      |=> can_filter_load_o && !nv_write_o)
      else $error("volatile CAN command not applied");
   c_clear: cover property (@(posedge ref_clk_i) state == ST_EXEC && cmd == CMD_CLR);
   c_persist: cover property (@(posedge ref_clk_i) reboot_cmd_o);
   c_error: cover property (@(posedge ref_clk_i) reply_start);
   c_volatile: cover property (@(posedge ref_clk_i) can_filter_load_o);
endmodule
`default_nettype wire

// >>> testbench/host_link_model.sv
// host-side model: reply sink with random stalls and a slow non-volatile store
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   input  wire logic       clk_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o,
   input  wire logic       nv_write_i,
   output logic            nv_done_o
);
   logic [7:0] got[$];
   int         wait_cnt = 2;
   // random stalls so every reply character must stand until taken
   always @(negedge clk_i) begin
      tx_ready_o <= 1'($urandom_range(0, 1));
      nv_done_o  <= 1'b0;
      // one done pulse per write, after a varying delay like a real store
      if (nv_write_i === 1'b1 && !nv_done_o) begin
         if (wait_cnt == 0) begin
            nv_done_o <= 1'b1;
            wait_cnt  <= $urandom_range(0, 6);
         end else begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end
   always @(posedge clk_i) begin
      if (tx_valid_i === 1'b1 && tx_ready_o) begin
         got.push_back(tx_data_i);
      end
   end
endmodule
`default_nettype wire

// >>> testbench/serial_config_command_parser_test.sv
// self-checking bench for the configuration command parser
`timescale 1ns/1ps
`default_nettype none
module serial_config_command_parser_test;
   import cfg_cmd_pkg::*;
   logic       ref_clk_i = 1'b0, arst_n_i = 1'b0, rx_valid_i = 1'b0, overflow_set_i = 1'b0;
   logic [7:0] rx_data_i = 8'h00, tx_data_o;
   logic       rx_ready_o, tx_valid_o, tx_ready_i, overflow_flag_o, fault_indicator_o;
   logic       nv_write_o, nv_link_sel_o, nv_done_i, reboot_cmd_o, cs_on = 1'b0, nv_sel_seen;
   logic       clk_en_i = 1'b1;
   logic [3:0] stored_can_rate_i = 4'h0, can_rate_o, nv_can_rate_o, nv_can_seen, cr;
   logic [63:0] can_filter_o, filt;
   link_cfg_s  stored_link_i = '0, link_cfg_o, nv_link_o, nv_link_seen, cfg;
   int         fails = 0, tests_run = 0, cycles = 0, reboots = 0, n;

   serial_config_command_parser #(.TIMEOUT_LIMIT(50)) serial_config_command_parser_inst (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
      .overflow_set_i(overflow_set_i), .stored_link_i(stored_link_i),
      .stored_can_rate_i(stored_can_rate_i), .overflow_flag_o(overflow_flag_o),
      .fault_indicator_o(fault_indicator_o), .link_cfg_o(link_cfg_o), .can_rate_o(can_rate_o),
      .can_filter_o(can_filter_o), .can_filter_load_o(),
      .nv_write_o(nv_write_o), .nv_link_o(nv_link_o),
      .nv_can_rate_o(nv_can_rate_o), .nv_link_sel_o(nv_link_sel_o), .nv_done_i(nv_done_i),
      .reboot_cmd_o(reboot_cmd_o));
   host_link_model host_link_model_inst (
      .clk_i(ref_clk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_ready_o(tx_ready_i), .nv_write_i(nv_write_o), .nv_done_o(nv_done_i));

   always #12.5 ref_clk_i = ~ref_clk_i;
   // =========================================================
   // monitors: store contents, reboot pulses, hang guard
   always @(posedge ref_clk_i) begin
      cycles++;
      if (reboot_cmd_o === 1'b1) reboots++;
      if (nv_write_o === 1'b1 && nv_done_i === 1'b1) begin
         nv_sel_seen  = nv_link_sel_o;
         nv_can_seen  = nv_can_rate_o;
         nv_link_seen = nv_link_o;
      end
      if (cycles == 60000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
   endfunction
   function automatic link_cfg_s rnd(input logic [3:0] r, input logic c, input logic e);
      rnd = '{r, 2'($urandom_range(0, 3)), 1'($urandom_range(0, 1)),
              2'($urandom_range(0, 2)), c, e};
   endfunction
   function automatic string lstr(input string h, input link_cfg_s k);
      return $sformatf("%s0%c%c%c%c%c%c", h, hx(k.link_rate_code), hx(4'(k.data_bits)),
                       hx(4'(k.two_stop)), hx(4'(k.parity)), hx(4'(k.checksum_on)),
                       hx(4'(k.err_reply_on)));
   endfunction
   // =========================================================
   // host side: valid is held until the device takes the character
   task automatic put(input logic [7:0] c);
      rx_valid_i = 1'b1;
      rx_data_i  = c;
      while (rx_ready_o !== 1'b1) @(negedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   // own loop counter: the scenarios keep a reboot count in n across this wait
   task automatic settle();
      int k;
      repeat (2) @(negedge ref_clk_i);
      for (k = 0; k < 500 && rx_ready_o !== 1'b1; k++) @(negedge ref_clk_i);
      repeat (3) @(negedge ref_clk_i);
   endtask
   task automatic send(input string s, input bit term);
      logic [7:0] sum;
      sum = 8'h00;
      host_link_model_inst.got.delete();
      foreach (s[i]) begin
         put(s[i]);
         sum += s[i];
      end
      if (term) begin
         if (cs_on) begin
            put(hx(sum[7:4]));
            put(hx(sum[3:0]));
         end
         put(CH_CR);
      end
      rx_valid_i = 1'b0;
      settle();
   endtask
   // error reply is question mark, code, checksum, CR; code 0 means none
   task automatic reply(input logic [3:0] code);
      logic [63:0] seen, exp;
      logic [7:0]  c, s;
      seen = '0;
      foreach (host_link_model_inst.got[i]) seen = {seen[55:0], host_link_model_inst.got[i]};
      seen[63:56] = 8'(host_link_model_inst.got.size());
      c = 8'h30 + 8'(code);
      s = CH_QMARK + c;
      exp = (code == 4'h0) ? 64'h0 : {8'h05, 16'h0, CH_QMARK, c, hx(s[7:4]), hx(s[3:0]), CH_CR};
      check(seen, exp);
   endtask
   // =========================================================
   initial begin
      void'($urandom(32'h8BA0941C));
      stored_link_i     = rnd(4'($urandom_range(0, 14)), 1'b0, 1'b1);
      stored_can_rate_i = 4'($urandom_range(0, 9));
      repeat (4) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      check(64'(link_cfg_o), 64'(stored_link_i));
      check(64'(can_rate_o), 64'(stored_can_rate_i));
      // a frozen clock enable must hold off the overflow event until enable returns
      clk_en_i = 1'b0;
      overflow_set_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      check(64'({overflow_flag_o, fault_indicator_o}), 64'h0);
      clk_en_i = 1'b1;
      @(negedge ref_clk_i);
      overflow_set_i = 1'b0;
      @(negedge ref_clk_i);
      check(64'({overflow_flag_o, fault_indicator_o}), 64'h3);
      send("C", 1);
      check(64'({overflow_flag_o, fault_indicator_o}), 64'h0);
      reply(4'h0);
      // every link rate code, data, stop and parity at random, checksum off, replies on
      for (int r = 0; r <= 14; r++) begin
         cfg = rnd(4'(r), 1'b0, 1'b1);
         send(lstr("P2", cfg), 1);
         check(64'(link_cfg_o), 64'(cfg));
      end
      send("X", 1);
      reply(ERR_HEADER);
      send("P14X", 1);
      reply(ERR_LENGTH);
      cfg = rnd(4'hB, 1'b1, 1'b1);
      send(lstr("P2", cfg), 1);
      cs_on = 1'b0;
      send("C00", 1);
      cs_on = 1'b1;
      reply(ERR_CHECKSUM);
      send("C", 1);
      reply(4'h0);
      // persistent CAN rate: codes 0..9 stored then reboot, code A refused
      for (int b = 0; b <= 10; b++) begin
         n = reboots;
         send($sformatf("P1%c", hx(4'(b))), 1);
         if (b < 10) check({nv_sel_seen, nv_can_seen, 32'(reboots - n)}, {1'b0, 4'(b), 32'd1});
         else reply(ERR_LENGTH);
      end
      cfg = rnd(4'($urandom_range(0, 14)), 1'b1, 1'b1);
      n = reboots;
      send(lstr("P0", cfg), 1);
      check({nv_sel_seen, nv_link_seen, 32'(reboots - n)}, {1'b1, cfg, 32'd1});
      // incomplete frame: nothing but a timeout reply
      send("P", 0);
      repeat (60) @(negedge ref_clk_i);
      settle();
      reply(ERR_TIMEOUT);
      cfg = rnd(4'h7, 1'b1, 1'b0);
      send(lstr("P2", cfg), 1);
      send("X", 1);
      reply(4'h0);
      // volatile CAN: rate and sixteen lower-case filter digits, dropped by a reboot
      cr = 4'($urandom_range(0, 9));
      filt = {$urandom, $urandom};
      send($sformatf("P3%c%h", hx(cr), filt), 1);
      check(64'(can_rate_o), 64'(cr));
      check(can_filter_o, filt);
      arst_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      check(64'(link_cfg_o), 64'(stored_link_i));
      check(64'(can_rate_o), 64'(stored_can_rate_i));
      end_of_test();
   end
endmodule
`default_nettype wire
